// file: lin_node_config_diagnostics.sv
// Purpose: Slave-side interpreter of LIN node configuration diagnostic requests.
// Assumes: A frame decoder on core_clk presents each complete request and each header.
// Notes: Responses are held until the next slave response header collects them or a newer response replaces them.
`timescale 1ns/1ps

module lin_node_config_diagnostics (
    input wire logic core_clk,
    input wire logic resetn,

    // Node configuration.
    input wire logic [1:0] compat_mode,
    input wire logic [7:0] cfg_nad,
    input wire logic [15:0] supplier_id,
    input wire logic [15:0] function_id,
    input wire logic [7:0] variant_id,
    input wire logic [31:0] serial_number,
    input wire logic [7:0] stored_nad,
    input wire logic [7:0] stored_status_pid,

    // Received request frame, one-cycle strobe with its bytes.
    input wire logic req_valid,
    input wire logic [7:0] req_pid,
    input wire logic [7:0] req_nad,
    input wire logic [7:0] req_pci,
    input wire logic [7:0] req_sid,
    input wire logic [7:0] req_data1,
    input wire logic [7:0] req_data2,
    input wire logic [7:0] req_data3,
    input wire logic [7:0] req_data4,
    input wire logic [7:0] req_data5,

    // Received header, one-cycle strobe.
    input wire logic hdr_valid,
    input wire logic [7:0] hdr_pid,

    // Response frame handed to the transmitter.
    output logic resp_valid,
    output logic resp_pending,
    output logic [7:0] resp_nad,
    output logic [7:0] resp_pci,
    output logic [7:0] resp_rsid,
    output logic [7:0] resp_data1,
    output logic [7:0] resp_data2,
    output logic [7:0] resp_data3,
    output logic [7:0] resp_data4,
    output logic [7:0] resp_data5,

    // Configurable signal-frame PIDs.
    output logic [7:0] status_frame_one_pid,
    output logic [7:0] status_frame_two_pid,
    output logic [7:0] status_frame_three_pid,
    output logic [7:0] self_check_frame_pid,

    // Nonvolatile memory requests, one-cycle pulses.
    output logic nvm_pid_store,
    output logic nvm_config_save
);

    // ********************************************************
    // Functions
    // ********************************************************

    // A frame slot number 1 to 4 is valid; 0 and anything above are not.
    function automatic logic slot_valid(input logic [15:0] slot);
        slot_valid = (slot != 16'h0000) && (slot <= lin_diag_pkg::MSG_ID_LAST);
    endfunction

    function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // ********************************************************
    // Reset release
    // ********************************************************
    logic rst_sync1_q;
    logic rst_sync2_q;
    wire rst_n = rst_sync2_q;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync1_q <= 1'b0;
            rst_sync2_q <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= rst_sync1_q;
        end
    end

    // ********************************************************
    // Request qualification
    // ********************************************************
    wire req_take = req_valid && (req_pid == lin_diag_pkg::PID_MASTER_REQ);
    wire hdr_take = hdr_valid && (hdr_pid == lin_diag_pkg::PID_SLAVE_RESP);
    wire [7:0] nad_func = 8'(cfg_nad + lin_diag_pkg::NAD_FUNC_OFFSET);
    wire nad_match = (req_nad == cfg_nad);
    wire nad_func_match = (req_nad == nad_func);
    wire mode_13 = (compat_mode == lin_diag_pkg::COMPAT_13);
    wire mode_20 = (compat_mode == lin_diag_pkg::COMPAT_20);
    wire mode_21 = (compat_mode == lin_diag_pkg::COMPAT_21);
    wire legacy_fid = (function_id == lin_diag_pkg::FUNC_ID_LEGACY);
    wire [15:0] msg_id = {req_data4, req_data3};
    wire [15:0] req_supplier = {req_data2, req_data1};

    wire sid_afi = (req_sid == lin_diag_pkg::SID_ASSIGN_FRAME_ID);
    wire sid_rbi = (req_sid == lin_diag_pkg::SID_READ_BY_ID);
    wire sid_dump = (req_sid == lin_diag_pkg::SID_DATA_DUMP);
    wire sid_save = (req_sid == lin_diag_pkg::SID_SAVE_CONFIG);
    wire sid_node_cfg = in_range(req_sid, lin_diag_pkg::SID_NODE_CFG_LO,
                                 lin_diag_pkg::SID_NODE_CFG_HI);
    wire sid_unsup = (req_sid <= lin_diag_pkg::SID_UNSUP_A_HI)
        || in_range(req_sid, lin_diag_pkg::SID_UNSUP_B_LO, lin_diag_pkg::SID_UNSUP_B_HI)
        || (req_sid >= lin_diag_pkg::SID_UNSUP_C_LO);

    // ********************************************************
    // Service decode
    // ********************************************************

    // Assignment succeeds for a well-formed 2.0-mode request naming this supplier and a valid slot.
    wire afi_req = req_take && nad_match && sid_afi && mode_20
        && (req_pci == lin_diag_pkg::PCI_AFI_REQ);
    wire afi_ok = (req_supplier == supplier_id) && slot_valid(msg_id);
    wire afi_commit = afi_req && afi_ok;

    wire rbi_req = req_take && nad_match && sid_rbi && (mode_20 || mode_21);
    wire dump_req = req_take && nad_match && sid_dump && !mode_13;
    wire save_req = req_take && nad_match && sid_save && !mode_13
        && (req_pci == lin_diag_pkg::PCI_SAVE_REQ);
    wire save_refuse = mode_20 && legacy_fid;

    // Unknown services: silent on the configured NAD except the legacy case.
    wire unk_cfg = req_take && nad_match && sid_unsup && mode_20 && legacy_fid;
    wire unk_func = req_take && nad_func_match && !sid_node_cfg;

    lin_diag_pkg::resp_kind_e kind;
    logic [7:0] neg_sid;
    logic [7:0] neg_code;

    always_comb begin
        kind = lin_diag_pkg::RK_NONE;
        neg_sid = req_sid;
        neg_code = lin_diag_pkg::ERR_UNKNOWN_SID;
        if (afi_req) begin
            if (afi_ok) begin
                kind = lin_diag_pkg::RK_AFI_POS;
            end else begin
                kind = lin_diag_pkg::RK_NEG;
                neg_code = lin_diag_pkg::ERR_OUT_OF_RANGE;
            end
        end else if (rbi_req) begin
            case (req_data1)
                lin_diag_pkg::RBI_ID_PRODUCT: kind = lin_diag_pkg::RK_RBI_PROD;
                lin_diag_pkg::RBI_ID_SERIAL: kind = lin_diag_pkg::RK_RBI_SER;
                lin_diag_pkg::RBI_ID_NVM_NODE: kind = lin_diag_pkg::RK_RBI_NVM;
                default: begin
                    kind = lin_diag_pkg::RK_NEG;
                    neg_code = lin_diag_pkg::ERR_OUT_OF_RANGE;
                end
            endcase
        end else if (dump_req) begin
            kind = lin_diag_pkg::RK_NEG;
            neg_code = lin_diag_pkg::ERR_NOT_SUPPORTED;
        end else if (save_req) begin
            if (save_refuse) begin
                kind = lin_diag_pkg::RK_NEG;
                neg_code = lin_diag_pkg::ERR_NOT_SUPPORTED;
            end else begin
                kind = lin_diag_pkg::RK_SAVE_POS;
            end
        end else if (unk_cfg || unk_func) begin
            kind = lin_diag_pkg::RK_NEG;
        end
    end

    // ********************************************************
    // Response assembly
    // ********************************************************
    logic [7:0] new_pci;
    logic [7:0] new_rsid;
    logic [7:0] new_d1;
    logic [7:0] new_d2;
    logic [7:0] new_d3;
    logic [7:0] new_d4;
    logic [7:0] new_d5;

    always_comb begin
        new_pci = lin_diag_pkg::PCI_POS_SHORT;
        new_rsid = lin_diag_pkg::FILL_BYTE;
        new_d1 = lin_diag_pkg::FILL_BYTE;
        new_d2 = lin_diag_pkg::FILL_BYTE;
        new_d3 = lin_diag_pkg::FILL_BYTE;
        new_d4 = lin_diag_pkg::FILL_BYTE;
        new_d5 = lin_diag_pkg::FILL_BYTE;
        case (kind)
            lin_diag_pkg::RK_AFI_POS: new_rsid = lin_diag_pkg::RSID_ASSIGN_FRAME_ID;
            lin_diag_pkg::RK_SAVE_POS: new_rsid = lin_diag_pkg::RSID_SAVE_CONFIG;
            lin_diag_pkg::RK_NEG: begin
                new_pci = lin_diag_pkg::PCI_NEG;
                new_rsid = lin_diag_pkg::RSID_NEGATIVE;
                new_d1 = neg_sid;
                new_d2 = neg_code;
            end
            lin_diag_pkg::RK_RBI_PROD: begin
                new_pci = lin_diag_pkg::PCI_RBI_PROD;
                new_rsid = lin_diag_pkg::RSID_READ_BY_ID;
                new_d1 = supplier_id[7:0];
                new_d2 = supplier_id[15:8];
                new_d3 = function_id[7:0];
                new_d4 = function_id[15:8];
                new_d5 = variant_id;
            end
            lin_diag_pkg::RK_RBI_SER: begin
                new_pci = lin_diag_pkg::PCI_RBI_SER;
                new_rsid = lin_diag_pkg::RSID_READ_BY_ID;
                new_d1 = serial_number[7:0];
                new_d2 = serial_number[15:8];
                new_d3 = serial_number[23:16];
                new_d4 = serial_number[31:24];
            end
            lin_diag_pkg::RK_RBI_NVM: begin
                new_pci = lin_diag_pkg::PCI_RBI_NVM;
                new_rsid = lin_diag_pkg::RSID_READ_BY_ID;
                new_d1 = stored_nad;
                new_d2 = stored_status_pid;
            end
            default: new_pci = lin_diag_pkg::PCI_POS_SHORT;
        endcase
    end

    wire new_resp = (kind != lin_diag_pkg::RK_NONE);

    // ********************************************************
    // Pending response buffer
    // ********************************************************
    logic pend_q;
    logic [7:0] pend_nad_q;
    logic [7:0] pend_pci_q;
    logic [7:0] pend_rsid_q;
    logic [7:0] pend_d1_q;
    logic [7:0] pend_d2_q;
    logic [7:0] pend_d3_q;
    logic [7:0] pend_d4_q;
    logic [7:0] pend_d5_q;

    // A request arriving with a header hands out the old response and keeps the new one.
    wire send_now = hdr_take && pend_q;
    wire pend_d = new_resp || (pend_q && !hdr_take);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_nad_q <= 8'h00;
            pend_pci_q <= 8'h00;
            pend_rsid_q <= 8'h00;
            pend_d1_q <= 8'h00;
            pend_d2_q <= 8'h00;
            pend_d3_q <= 8'h00;
            pend_d4_q <= 8'h00;
            pend_d5_q <= 8'h00;
        end else if (new_resp) begin
            pend_nad_q <= req_nad;
            pend_pci_q <= new_pci;
            pend_rsid_q <= new_rsid;
            pend_d1_q <= new_d1;
            pend_d2_q <= new_d2;
            pend_d3_q <= new_d3;
            pend_d4_q <= new_d4;
            pend_d5_q <= new_d5;
        end
    end

    // ********************************************************
    // Response output
    // ********************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_valid <= 1'b0;
            resp_nad <= 8'h00;
            resp_pci <= 8'h00;
            resp_rsid <= 8'h00;
            resp_data1 <= 8'h00;
            resp_data2 <= 8'h00;
            resp_data3 <= 8'h00;
            resp_data4 <= 8'h00;
            resp_data5 <= 8'h00;
        end else begin
            resp_valid <= send_now;
            if (send_now) begin
                resp_nad <= pend_nad_q;
                resp_pci <= pend_pci_q;
                resp_rsid <= pend_rsid_q;
                resp_data1 <= pend_d1_q;
                resp_data2 <= pend_d2_q;
                resp_data3 <= pend_d3_q;
                resp_data4 <= pend_d4_q;
                resp_data5 <= pend_d5_q;
            end
        end
    end

    assign resp_pending = pend_q;

    // ********************************************************
    // Signal-frame PIDs and nonvolatile requests
    // ********************************************************
    wire [7:0] new_pid = req_data5;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_frame_one_pid <= lin_diag_pkg::RST_STATUS_ONE_PID;
            status_frame_two_pid <= lin_diag_pkg::RST_STATUS_TWO_PID;
            status_frame_three_pid <= lin_diag_pkg::RST_STATUS_THREE_PID;
            self_check_frame_pid <= lin_diag_pkg::RST_SELF_CHECK_PID;
        end else if (afi_commit) begin
            case (msg_id[2:0])
                3'h1: status_frame_one_pid <= new_pid;
                3'h2: status_frame_two_pid <= new_pid;
                3'h3: status_frame_three_pid <= new_pid;
                3'h4: self_check_frame_pid <= new_pid;
                default: status_frame_one_pid <= status_frame_one_pid;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            nvm_pid_store <= 1'b0;
            nvm_config_save <= 1'b0;
        end else begin
            nvm_pid_store <= afi_commit;
            nvm_config_save <= save_req && !save_refuse;
        end
    end

endmodule

// file: lin_diag_pkg.sv
// Purpose: Shared constants and types for the LIN node configuration diagnostic interpreter.
// Assumes: Byte values are those carried in LIN diagnostic frames, eight bits each.
// Notes: Every frame code, offset and signal-frame PID reset value used by the design is named here once.
package lin_diag_pkg;

    // ********************************************************
    // Compatibility modes
    // ********************************************************
    typedef enum logic [1:0] {
        COMPAT_13 = 2'b00,
        COMPAT_20 = 2'b01,
        COMPAT_21 = 2'b10
    } compat_e;

    // ********************************************************
    // Response kinds
    // ********************************************************
    typedef enum logic [2:0] {
        RK_NONE     = 3'b000,
        RK_AFI_POS  = 3'b001,
        RK_NEG      = 3'b010,
        RK_RBI_PROD = 3'b011,
        RK_RBI_SER  = 3'b100,
        RK_RBI_NVM  = 3'b101,
        RK_SAVE_POS = 3'b110
    } resp_kind_e;

    // ********************************************************
    // Frame identifiers and byte codes
    // ********************************************************
    localparam logic [7:0] PID_MASTER_REQ = 8'h3C;
    localparam logic [7:0] PID_SLAVE_RESP = 8'h7D;
    localparam logic [7:0] NAD_FUNC_OFFSET = 8'h80;
    localparam logic [7:0] FILL_BYTE = 8'hFF;

    localparam logic [7:0] SID_ASSIGN_FRAME_ID = 8'hB1;
    localparam logic [7:0] SID_READ_BY_ID = 8'hB2;
    localparam logic [7:0] SID_DATA_DUMP = 8'hB4;
    localparam logic [7:0] SID_SAVE_CONFIG = 8'hB6;
    localparam logic [7:0] SID_NODE_CFG_LO = 8'hB0;
    localparam logic [7:0] SID_NODE_CFG_HI = 8'hB7;
    localparam logic [7:0] SID_UNSUP_A_HI = 8'h21;
    localparam logic [7:0] SID_UNSUP_B_LO = 8'h23;
    localparam logic [7:0] SID_UNSUP_B_HI = 8'hAF;
    localparam logic [7:0] SID_UNSUP_C_LO = 8'hB8;

    localparam logic [7:0] RSID_ASSIGN_FRAME_ID = 8'hF1;
    localparam logic [7:0] RSID_READ_BY_ID = 8'hF2;
    localparam logic [7:0] RSID_SAVE_CONFIG = 8'hF6;
    localparam logic [7:0] RSID_NEGATIVE = 8'h7F;

    localparam logic [7:0] PCI_AFI_REQ = 8'h06;
    localparam logic [7:0] PCI_SAVE_REQ = 8'h01;
    localparam logic [7:0] PCI_POS_SHORT = 8'h01;
    localparam logic [7:0] PCI_NEG = 8'h03;
    localparam logic [7:0] PCI_RBI_PROD = 8'h06;
    localparam logic [7:0] PCI_RBI_SER = 8'h05;
    localparam logic [7:0] PCI_RBI_NVM = 8'h03;

    localparam logic [7:0] ERR_NOT_SUPPORTED = 8'h11;
    localparam logic [7:0] ERR_OUT_OF_RANGE = 8'h12;
    localparam logic [7:0] ERR_UNKNOWN_SID = 8'h13;

    localparam logic [7:0] RBI_ID_PRODUCT = 8'h00;
    localparam logic [7:0] RBI_ID_SERIAL = 8'h01;
    localparam logic [7:0] RBI_ID_NVM_NODE = 8'h21;

    localparam logic [15:0] FUNC_ID_LEGACY = 16'h0001;
    localparam logic [15:0] MSG_ID_LAST = 16'h0004;

    // ********************************************************
    // Reset values of the configurable signal-frame PIDs
    // ********************************************************
    localparam logic [7:0] RST_STATUS_ONE_PID = 8'h00;
    localparam logic [7:0] RST_STATUS_TWO_PID = 8'h00;
    localparam logic [7:0] RST_STATUS_THREE_PID = 8'h00;
    localparam logic [7:0] RST_SELF_CHECK_PID = 8'h00;

endpackage

// file: lin_diag_asserts.sv
// Purpose: Concurrent checks on the ports of the diagnostic interpreter.
// Assumes: Requests and headers arrive as one-cycle strobes on core_clk.
// Notes: Bound into every instance of the interpreter.
`timescale 1ns/1ps
module lin_diag_asserts (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [1:0] compat_mode,
    input wire logic [7:0] cfg_nad,
    input wire logic [15:0] supplier_id,
    input wire logic req_valid,
    input wire logic [7:0] req_pid,
    input wire logic [7:0] req_nad,
    input wire logic [7:0] req_pci,
    input wire logic [7:0] req_sid,
    input wire logic [7:0] req_data1,
    input wire logic [7:0] req_data2,
    input wire logic [7:0] req_data3,
    input wire logic [7:0] req_data4,
    input wire logic [7:0] req_data5,
    input wire logic hdr_valid,
    input wire logic [7:0] hdr_pid,
    input wire logic resp_valid,
    input wire logic resp_pending,
    input wire logic [7:0] resp_nad,
    input wire logic [7:0] resp_pci,
    input wire logic [7:0] status_frame_one_pid,
    input wire logic nvm_pid_store,
    input wire logic nvm_config_save
);
    // ******************************
    // Request, header and response checks
    // ******************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_req_ok;
        req_valid && req_pid == 8'h3C && req_nad == cfg_nad;
    endsequence
    sequence s_collect;
        resp_pending && hdr_valid && hdr_pid == 8'h7D;
    endsequence
    a_hdr_collects: assert property (s_collect |=> resp_valid)
        else $error("pending response not sent after slave header");
    a_resp_cause: assert property (resp_valid |-> $past(resp_pending && hdr_valid))
        else $error("response sent without pending response and header");
    a_rbi_answer: assert property (s_req_ok ##0 (req_sid == 8'hB2
        && req_data1 == 8'h00 && {req_data3, req_data2} == supplier_id
        && compat_mode == 2'h2) |=> resp_pending)
        else $error("read by identifier drew no response");
    a_dump_silent: assert property (s_req_ok ##0 (req_sid == 8'hB4
        && compat_mode == 2'h0 && !resp_pending) |=> !resp_pending)
        else $error("data dump answered in 1.3 mode");
    a_afi_store: assert property (s_req_ok ##0 (req_pci == 8'h06
        && req_sid == 8'hB1 && compat_mode == 2'h1 && {req_data2, req_data1} == supplier_id
        && {req_data4, req_data3} == 16'h0001)
        |=> nvm_pid_store && status_frame_one_pid == $past(req_data5))
        else $error("frame identifier assignment not stored");
    a_store_cause: assert property (nvm_pid_store
        |-> $past(req_valid && req_sid == 8'hB1))
        else $error("identifier store without assignment request");
    a_save_pulse: assert property (s_req_ok ##0 (req_pci == 8'h01 && req_sid == 8'hB6
        && compat_mode == 2'h2) |=> nvm_config_save)
        else $error("save configuration not written");
    a_bytes_hold: assert property (!resp_valid
        |-> $stable(resp_pci) && $stable(resp_nad))
        else $error("response bytes changed without a response");
    a_nad80_silent: assert property (req_valid && req_pid == 8'h3C
        && req_nad == cfg_nad + 8'h80 && req_sid inside {[8'hB0:8'hB7]}
        && !resp_pending && !hdr_valid |=> !resp_pending)
        else $error("functional NAD node service answered");
endmodule
bind lin_node_config_diagnostics lin_diag_asserts i_lin_diag_asserts (.*);

// file: lin_master_model.sv
// Purpose: Behavioural master issuing diagnostic requests and headers.
// Assumes: One send covers one request, one header or both; strobes last one cycle.
// Notes: Released request bytes show the inverse of the last value.
`timescale 1ns/1ps
module lin_master_model (
    input wire logic core_clk,
    output logic req_valid,
    output logic [7:0] req_pid,
    output logic [63:0] req_bytes,
    output logic hdr_valid,
    output logic [7:0] hdr_pid
);
    initial begin
        req_valid = 1'b0;
        req_pid = 8'h00;
        req_bytes = 64'h0;
        hdr_valid = 1'b0;
        hdr_pid = 8'h00;
    end
    task automatic send(input logic rq, input logic hd, input logic [7:0] pid,
                        input logic [63:0] f);
        @(posedge core_clk);
        req_valid <= rq;
        hdr_valid <= hd;
        req_pid <= pid;
        hdr_pid <= 8'h7D;
        req_bytes <= f;
        @(posedge core_clk);
        req_valid <= 1'b0;
        hdr_valid <= 1'b0;
        req_pid <= ~pid;
        hdr_pid <= 8'h82;
        req_bytes <= ~f;
    endtask
endmodule

// file: lin_node_config_diagnostics_tb_top.sv
// Purpose: Self-checking bench for the diagnostic interpreter.
// Assumes: The master model drives requests and headers at rising edges.
// Notes: Table rows first, then side effects, ordering and reset cases.
`timescale 1ns/1ps
module lin_node_config_diagnostics_tb_top;
    // ******************************
    // Table and signals
    // ******************************
    typedef struct packed {
        logic [1:0] mode;
        logic [15:0] fid;
        logic [63:0] req;
        logic [56:0] exp;
    } row_s;
    localparam logic [1:0] M13 = 2'h0;
    localparam logic [1:0] M20 = 2'h1;
    localparam logic [1:0] M21 = 2'h2;
    localparam logic [15:0] F1 = 16'h0001;
    localparam logic [15:0] F2 = 16'h0002;
    localparam logic [56:0] NB2 = 57'h1037FB212FFFFFF;
    localparam logic [56:0] NB1 = 57'h1037FB112FFFFFF;
    row_s rows [21] = '{
        {M21, F2, 64'h1506B20034120200, 57'h106F2341202005A},
        {M21, F2, 64'h1506B20134120200, 57'h105F2EFCDAB89FF},
        {M20, F2, 64'h1506B22134120200, 57'h103F23344FFFFFF},
        {M21, F2, 64'h1506B20234120200, NB2},
        {M21, F2, 64'h1506B22234120200, NB2},
        {M13, F2, 64'h1506B20034120200, 57'h0},
        {M20, F2, 64'h1506B4AABBCCDDEE, 57'h1037FB411FFFFFF},
        {M13, F2, 64'h1506B4AABBCCDDEE, 57'h0},
        {M21, F2, 64'h1501B6FFFFFFFFFF, 57'h101F6FFFFFFFFFF},
        {M20, F1, 64'h1501B6FFFFFFFFFF, 57'h1037FB611FFFFFF},
        {M20, F1, 64'h150621FFFFFFFFFF, 57'h1037F2113FFFFFF},
        {M20, F1, 64'h150623FFFFFFFFFF, 57'h1037F2313FFFFFF},
        {M20, F1, 64'h1506AFFFFFFFFFFF, 57'h1037FAF13FFFFFF},
        {M20, F1, 64'h1506B8FFFFFFFFFF, 57'h1037FB813FFFFFF},
        {M21, F2, 64'h150621FFFFFFFFFF, 57'h0},
        {M21, F2, 64'h9506B20034120200, 57'h0},
        {M13, F2, 64'h950650FFFFFFFFFF, 57'h1037F5013FFFFFF},
        {M20, F2, 64'h1506B13412000020, NB1},
        {M20, F2, 64'h1506B13412050020, NB1},
        {M20, F2, 64'h1506B13512010020, NB1},
        {M21, F2, 64'h1506B13412010020, 57'h0}
    };
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] compat_mode = M21;
    logic [15:0] function_id = F2;
    logic [7:0] cfg_nad = 8'h15;
    logic req_valid;
    logic hdr_valid;
    logic [7:0] req_pid;
    logic [7:0] hdr_pid;
    logic [63:0] req_bytes;
    wire [63:0] resp;
    wire [31:0] pids;
    wire resp_valid;
    wire resp_pending;
    wire nvm_pid_store;
    wire nvm_config_save;
    int fail_count = 0;
    int num_checks = 0;
    always #4 core_clk = ~core_clk;
    lin_master_model i_lin_master_model (.core_clk(core_clk), .req_valid(req_valid),
        .req_pid(req_pid), .req_bytes(req_bytes), .hdr_valid(hdr_valid), .hdr_pid(hdr_pid));
    lin_node_config_diagnostics i_lin_node_config_diagnostics (
        .core_clk(core_clk), .resetn(resetn), .compat_mode(compat_mode), .cfg_nad(cfg_nad),
        .supplier_id(16'h1234), .function_id(function_id), .variant_id(8'h5A),
        .serial_number(32'h89ABCDEF), .stored_nad(8'h33), .stored_status_pid(8'h44),
        .req_valid(req_valid), .req_pid(req_pid), .req_nad(req_bytes[63:56]),
        .req_pci(req_bytes[55:48]), .req_sid(req_bytes[47:40]), .req_data1(req_bytes[39:32]),
        .req_data2(req_bytes[31:24]), .req_data3(req_bytes[23:16]), .req_data4(req_bytes[15:8]),
        .req_data5(req_bytes[7:0]), .hdr_valid(hdr_valid), .hdr_pid(hdr_pid),
        .resp_valid(resp_valid), .resp_pending(resp_pending), .resp_nad(resp[63:56]),
        .resp_pci(resp[55:48]), .resp_rsid(resp[47:40]), .resp_data1(resp[39:32]),
        .resp_data2(resp[31:24]), .resp_data3(resp[23:16]), .resp_data4(resp[15:8]),
        .resp_data5(resp[7:0]), .status_frame_one_pid(pids[31:24]),
        .status_frame_two_pid(pids[23:16]), .status_frame_three_pid(pids[15:8]),
        .self_check_frame_pid(pids[7:0]), .nvm_pid_store(nvm_pid_store),
        .nvm_config_save(nvm_config_save));
    // ******************************
    // Checking tasks
    // ******************************
    task automatic chk_val(input logic [63:0] e, input logic [63:0] a);
        num_checks++;
        if (a !== e) begin
            fail_count++;
            $display("ERROR t=%0t exp=%h act=%h", $time, e, a);
        end
    endtask
    task automatic chk_bit(input logic e, input logic a);
        chk_val({63'h0, e}, {63'h0, a});
    endtask
    task automatic finish_test();
        $display("checks=%0d errors=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // A row sends its request, then a header, and checks what the header collects.
    task automatic run(input row_s r);
        @(posedge core_clk);
        compat_mode <= r.mode;
        function_id <= r.fid;
        i_lin_master_model.send(1'b1, 1'b0, 8'h3C, r.req);
        #1;
        chk_bit(r.exp[56], resp_pending);
        i_lin_master_model.send(1'b0, 1'b1, 8'h00, 64'h0);
        #1;
        chk_bit(r.exp[56], resp_valid);
        if (r.exp[56])
            chk_val({8'h00, r.exp[55:0]}, {8'h00, resp[55:0]});
    endtask
    initial begin
        row_s r;
        repeat (3) @(posedge core_clk);
        chk_bit(1'b0, resp_pending);
        chk_val(64'h0, {32'h0, pids});
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        foreach (rows[i]) run(rows[i]);
        for (int i = 1; i <= 4; i++) begin
            r = {M20, F2, 40'h1506B13412, 8'(i), 8'h00, 8'(8'h30 + i), 57'h101F1FFFFFFFFFF};
            run(r);
        end
        chk_val(64'h31323334, {32'h0, pids});
        @(posedge core_clk);
        compat_mode <= M21;
        i_lin_master_model.send(1'b1, 1'b0, 8'h3C, 64'h1506B20034120200);
        i_lin_master_model.send(1'b1, 1'b0, 8'h3C, 64'h1506B20134120200);
        i_lin_master_model.send(1'b1, 1'b1, 8'h3C, 64'h1506B22134120200);
        #1;
        chk_val(64'h1505F2EFCDAB89FF, resp);
        chk_bit(1'b1, resp_pending);
        i_lin_master_model.send(1'b0, 1'b1, 8'h00, 64'h0);
        #1;
        chk_val(64'h1503F23344FFFFFF, resp);
        @(posedge core_clk);
        cfg_nad <= 8'h2A;
        run({M21, F2, 64'h1506B20034120200, 57'h0});
        i_lin_master_model.send(1'b1, 1'b0, 8'h3D, 64'h2A06B20034120200);
        #1;
        chk_bit(1'b0, resp_pending);
        i_lin_master_model.send(1'b1, 1'b0, 8'h3C, 64'h2A06B20034120200);
        resetn <= 1'b0;
        @(posedge core_clk);
        #1;
        chk_bit(1'b0, resp_pending);
        chk_val(64'h0, {32'h0, pids});
        @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        run({M21, F2, 64'h2A06B20034120200, 57'h106F2341202005A});
        chk_bit(1'b0, resp_pending);
        finish_test();
    end
    initial begin
        #100000;
        fail_count++;
        finish_test();
    end
endmodule
